/* File: dv/sar_adc_control_readout_tb.sv */
// Self-checking bench for the converter control block over AHB-Lite
`timescale 1ns/1ns
module sar_adc_control_readout_tb;
  // ******************************
  // Signals and instance
  // ******************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout, hresp, converter_enable, sample_hold, done_irq;
  logic [31:0] hrdata;
  logic comp_above = 1'b0;
  logic halt_mode = 1'b0;
  logic [3:0] channel_sel;
  logic [9:0] dac_code;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  sar_adc_control_readout sar_adc_control_readout_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_above(comp_above), .halt_mode(halt_mode),
    .converter_enable(converter_enable), .sample_hold(sample_hold), .channel_sel(channel_sel),
    .dac_code(dac_code), .done_irq(done_irq));
  // ******************************
  // Bus and compare tasks
  // ******************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h0, d}, r);
  endtask : wr
  task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask : rdc
  // Polls only the status register, which must not disturb the done flag
  task automatic wait_done();
    logic [31:0] r;
    int k;
    r = 32'h0;
    k = 0;
    while (r[7] !== 1'b1 && k < 3000) begin
      xfer(1'b0, adc_ctl_pkg::ADDR_CSR, 32'h0, r);
      k++;
    end
    chk("done flag", 32'h1, {31'h0, r[7]});
  endtask : wait_done
  // Cycles between two sampling starts, seen at falling edges away from updates
  task automatic period(output int p);
    @(posedge sample_hold);
    @(negedge hclk);
    p = 0;
    while (sample_hold !== 1'b0) begin
      @(negedge hclk);
      p++;
    end
    while (sample_hold !== 1'b1) begin
      @(negedge hclk);
      p++;
    end
  endtask : period
  task automatic settle();
    repeat (2) @(negedge hclk);
  endtask : settle
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // ******************************
  // Watchdog
  // ******************************
  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    test_done();
  end
  // ******************************
  // Tests
  // ******************************
  initial begin
    int tick [3];
    tick = '{13, 25, 50};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("status reset", adc_ctl_pkg::ADDR_CSR, 32'h0);
    rdc("upper reset", adc_ctl_pkg::ADDR_UPPER, 32'h0);
    rdc("lower reset", adc_ctl_pkg::ADDR_LOWER, 32'h0);
    rdc("unmapped read", 10'h000, 32'h0);
    chk("bus ready okay", 32'h1, {30'h0, hresp, hreadyout});
    wr(adc_ctl_pkg::ADDR_CSR, 8'hFF);
    rdc("status all ones", adc_ctl_pkg::ADDR_CSR, 32'h7F);
    for (int i = 0; i < 16; i++) begin
      wr(adc_ctl_pkg::ADDR_CSR, 8'(i));
      settle();
      chk("channel select", 32'(i), {28'h0, channel_sel});
    end
    comp_above <= 1'b1;
    wr(adc_ctl_pkg::ADDR_CLKCTL, 8'h01);
    wr(adc_ctl_pkg::ADDR_CSR, 8'h13);
    settle();
    chk("converter on", 32'h1, {31'h0, converter_enable});
    rdc("done low running", adc_ctl_pkg::ADDR_CSR, 32'h13);
    wait_done();
    settle();
    chk("irq raised", 32'h1, {31'h0, done_irq});
    // Lower first, then upper: the two halves must come from one sample
    rdc("lower saturated", adc_ctl_pkg::ADDR_LOWER, 32'h3);
    comp_above <= 1'b0;
    repeat (2) @(posedge sample_hold);
    rdc("upper frozen", adc_ctl_pkg::ADDR_UPPER, 32'hFF);
    rdc("done cleared", adc_ctl_pkg::ADDR_CSR, 32'h13);
    settle();
    chk("irq dropped", 32'h0, {31'h0, done_irq});
    wait_done();
    rdc("lower zero", adc_ctl_pkg::ADDR_LOWER, 32'h0);
    rdc("upper zero", adc_ctl_pkg::ADDR_UPPER, 32'h0);
    wait_done();
    rdc("upper only", adc_ctl_pkg::ADDR_UPPER, 32'h0);
    rdc("done after upper", adc_ctl_pkg::ADDR_CSR, 32'h13);
    rdc("freeze again", adc_ctl_pkg::ADDR_LOWER, 32'h0);
    comp_above <= 1'b1;
    wr(adc_ctl_pkg::ADDR_CSR, 8'h03);
    settle();
    chk("converter off", 32'h0, {31'h0, converter_enable});
    wr(adc_ctl_pkg::ADDR_CSR, 8'h13);
    wait_done();
    rdc("lower unfrozen", adc_ctl_pkg::ADDR_LOWER, 32'h3);
    rdc("upper unfrozen", adc_ctl_pkg::ADDR_UPPER, 32'hFF);
    wait_done();
    wr(adc_ctl_pkg::ADDR_CSR, 8'h15);
    rdc("channel restart", adc_ctl_pkg::ADDR_CSR, 32'h15);
    settle();
    chk("new channel", 32'h5, {28'h0, channel_sel});
    halt_mode <= 1'b1;
    repeat (6) @(negedge hclk);
    chk("halt off", 32'h0, {31'h0, converter_enable});
    halt_mode <= 1'b0;
    repeat (6) @(negedge hclk);
    chk("halt wake", 32'h1, {31'h0, converter_enable});
    // Sampling spans 3 ticks, trials 10 ticks; divider sets the tick length
    for (int d = 0; d < 3; d++) begin
      wr(adc_ctl_pkg::ADDR_CSR, 8'h00);
      wr(adc_ctl_pkg::ADDR_CSR, {1'b0, 2'(d), 1'b1, 4'h0});
      period(n);
      chk("conversion period", 32'(13 * tick[d]), 32'(n));
    end
    wr(adc_ctl_pkg::ADDR_CLKCTL, 8'h02);
    wr(adc_ctl_pkg::ADDR_CSR, 8'h00);
    wr(adc_ctl_pkg::ADDR_CSR, 8'h10);
    period(n);
    chk("long sample period", 32'(16 * 13), 32'(n));
    test_done();
  end
endmodule : sar_adc_control_readout_tb

/* File: rtl/adc_ctl_pkg.sv */
// Constants and types shared by the converter control block
package adc_ctl_pkg;
  // ******************************
  // Register map (index, byte address = 4 x index)
  // ******************************
  localparam logic [7:0] IDX_CSR = 8'h2E;
  localparam logic [7:0] IDX_UPPER = 8'h2F;
  localparam logic [7:0] IDX_LOWER = 8'h30;
  localparam logic [7:0] IDX_CLKCTL = 8'h31;
  localparam logic [9:0] ADDR_CSR = {IDX_CSR, 2'b00};
  localparam logic [9:0] ADDR_UPPER = {IDX_UPPER, 2'b00};
  localparam logic [9:0] ADDR_LOWER = {IDX_LOWER, 2'b00};
  localparam logic [9:0] ADDR_CLKCTL = {IDX_CLKCTL, 2'b00};
  // ******************************
  // Field positions and reset values
  // ******************************
  localparam int BIT_EOC = 7;
  localparam int DIV_LSB = 5;
  localparam int BIT_ON = 4;
  localparam int CH_LSB = 0;
  localparam int BIT_IE = 0;
  localparam int BIT_LS = 1;
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] UPPER_RST = 8'h00;
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam logic [1:0] CLKCTL_RST = 2'h0;
  // ******************************
  // Timing
  // ******************************
  localparam int ADC_HZ_FAST = 4_000_000;
  localparam int ADC_HZ_MID = 2_000_000;
  localparam int ADC_HZ_SLOW = 1_000_000;
  localparam int SAMPLE_TICKS = 3;
  localparam int SAMPLE_TICKS_LONG = 6;
  localparam int STAB_TIME_NS = 10_000;
  localparam int RESULT_W = 10;
  typedef enum {ST_OFF, ST_STAB, ST_SAMPLE, ST_CONVERT} conv_state_t;
endpackage : adc_ctl_pkg

/* File: rtl/sar_adc_control_readout.sv */
// Successive-approximation converter control, result readout and AHB-Lite registers
`timescale 1ns/1ns
// Functional notes
// - Setting on bit starts continuous conversion
// - Clearing on bit stops and aborts conversion
// - Done flag low from a start or upper read until the next completion
// - Completion sets done flag, stores result
// - Interrupt on completion only when enabled
// - Upper register read or a fresh start clears done
// - Channel write restarts conversion on new input
// - Lower register read freezes both results
// - Upper read or on-bit clear unfreezes
// - Frozen results ignore new conversions
// - Upper-only read gives eight bits, clears done
// - Over-range input saturates to all ones
// - Under-range input gives zero result
// - Divider codes give 4, 2, 1 MHz
// - Four-bit code selects input zero to fifteen
// - Control register writable except done bit
// - Upper holds bits 9:2, lower 1:0
// - All registers reset to zero
// - Wait ignored, halt disables, then stabilise
// - Long-sample bit stretches sampling time
module sar_adc_control_readout #(
  parameter int CLK_HZ = 50_000_000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic comp_above,
  input wire logic halt_mode,
  output logic converter_enable,
  output logic sample_hold,
  output logic [3:0] channel_sel,
  output logic [9:0] dac_code,
  output logic done_irq
);
  // ******************************
  // Derived counts
  // ******************************
  // Round up so the converter clock never runs above its nominal rate
  localparam int DIV_FAST = (CLK_HZ + adc_ctl_pkg::ADC_HZ_FAST - 1) / adc_ctl_pkg::ADC_HZ_FAST;
  localparam int DIV_MID = (CLK_HZ + adc_ctl_pkg::ADC_HZ_MID - 1) / adc_ctl_pkg::ADC_HZ_MID;
  localparam int DIV_SLOW = (CLK_HZ + adc_ctl_pkg::ADC_HZ_SLOW - 1) / adc_ctl_pkg::ADC_HZ_SLOW;
  localparam longint STAB_RAW = (longint'(adc_ctl_pkg::STAB_TIME_NS) * CLK_HZ + 999_999_999) / 1_000_000_000;
  localparam int STAB_CYCLES = (STAB_RAW < 1) ? 1 : int'(STAB_RAW);

  initial begin
    if (DIV_SLOW > 255 || DIV_FAST < 2 || STAB_CYCLES > 65535) begin
      $error("CLK_HZ out of the range this divider serves");
    end
  end

  // ******************************
  // Functions
  // ******************************
  function automatic logic [7:0] div_last(input logic [1:0] code);
    unique case (code)
      2'b00: div_last = 8'(DIV_FAST - 1);
      2'b01: div_last = 8'(DIV_MID - 1);
      default: div_last = 8'(DIV_SLOW - 1);
    endcase
  endfunction : div_last

  function automatic logic hit(input logic [9:0] a, input logic [9:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // ******************************
  // Declarations
  // ******************************
  adc_ctl_pkg::conv_state_t state_r, state_nxt;
  logic comp_m_r, comp_s_r, halt_m_r, halt_s_r;
  logic on_r, ie_r, ls_r, eoc_r, lock_r, wr_pend_r;
  logic [1:0] div_r;
  logic [3:0] chan_r, bit_r, step_r;
  logic [7:0] div_cnt_r;
  logic [9:0] wr_addr_r, sar_r;
  logic [9:0] result_r;
  logic [15:0] stab_r;
  logic [31:0] hrdata_r;

  // ******************************
  // Bus decode
  // ******************************
  wire accept = hsel && htrans[1] && hready;
  wire [9:0] a_lo = haddr[9:0];
  wire rd_acc = accept && !hwrite;
  wire rd_upper = rd_acc && hit(a_lo, adc_ctl_pkg::ADDR_UPPER);
  wire rd_lower = rd_acc && hit(a_lo, adc_ctl_pkg::ADDR_LOWER);
  wire rd_csr = rd_acc && hit(a_lo, adc_ctl_pkg::ADDR_CSR);
  wire rd_ctl = rd_acc && hit(a_lo, adc_ctl_pkg::ADDR_CLKCTL);
  wire wr_csr = wr_pend_r && hit(wr_addr_r, adc_ctl_pkg::ADDR_CSR);
  wire wr_ctl = wr_pend_r && hit(wr_addr_r, adc_ctl_pkg::ADDR_CLKCTL);

  // Writes land in the data phase; a read in that same cycle sees the new value
  wire on_nxt = wr_csr ? hwdata[adc_ctl_pkg::BIT_ON] : on_r;
  wire [1:0] div_nxt = wr_csr ? hwdata[adc_ctl_pkg::DIV_LSB +: 2] : div_r;
  wire [3:0] chan_nxt = wr_csr ? hwdata[adc_ctl_pkg::CH_LSB +: 4] : chan_r;
  wire ie_nxt = wr_ctl ? hwdata[adc_ctl_pkg::BIT_IE] : ie_r;
  wire ls_nxt = wr_ctl ? hwdata[adc_ctl_pkg::BIT_LS] : ls_r;

  // ******************************
  // Conversion control
  // ******************************
  wire turn_on = wr_csr && on_nxt && !on_r;
  wire chan_change = wr_csr && on_r && on_nxt && (chan_nxt != chan_r);
  wire start = turn_on || chan_change;
  wire turn_off = wr_csr && !on_nxt;
  wire tick = (div_cnt_r == 8'h00);
  wire [3:0] samp_last = ls_r ? 4'(adc_ctl_pkg::SAMPLE_TICKS_LONG - 1)
                              : 4'(adc_ctl_pkg::SAMPLE_TICKS - 1);
  wire [9:0] trial = 10'(1) << bit_r;
  // Keep the trial bit while the input is above the trial level; rails give 3FF or 000
  wire [9:0] sar_kept = comp_s_r ? sar_r : (sar_r & ~trial);
  wire conv_done = (state_r == adc_ctl_pkg::ST_CONVERT) && tick && (bit_r == 4'h0)
                   && on_nxt && !start && !halt_s_r;

  always_comb begin
    state_nxt = state_r;
    if (!on_nxt || halt_s_r) begin
      state_nxt = adc_ctl_pkg::ST_OFF;
    end else if (start) begin
      state_nxt = adc_ctl_pkg::ST_SAMPLE;
    end else begin
      unique case (state_r)
        adc_ctl_pkg::ST_OFF: state_nxt = adc_ctl_pkg::ST_STAB;
        adc_ctl_pkg::ST_STAB: begin
          if (stab_r == 16'h0000) state_nxt = adc_ctl_pkg::ST_SAMPLE;
        end
        adc_ctl_pkg::ST_SAMPLE: begin
          if (tick && step_r == samp_last) state_nxt = adc_ctl_pkg::ST_CONVERT;
        end
        adc_ctl_pkg::ST_CONVERT: begin
          if (conv_done) state_nxt = adc_ctl_pkg::ST_SAMPLE;
        end
      endcase
    end
  end

  // ******************************
  // Synchronisers
  // ******************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_m_r <= 1'b0;
      comp_s_r <= 1'b0;
      halt_m_r <= 1'b0;
      halt_s_r <= 1'b0;
    end else begin
      comp_m_r <= comp_above;
      comp_s_r <= comp_m_r;
      halt_m_r <= halt_mode;
      halt_s_r <= halt_m_r;
    end
  end

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_r <= adc_ctl_pkg::CSR_RST[adc_ctl_pkg::BIT_ON];
      div_r <= adc_ctl_pkg::CSR_RST[adc_ctl_pkg::DIV_LSB +: 2];
      chan_r <= adc_ctl_pkg::CSR_RST[adc_ctl_pkg::CH_LSB +: 4];
      eoc_r <= adc_ctl_pkg::CSR_RST[adc_ctl_pkg::BIT_EOC];
      ie_r <= adc_ctl_pkg::CLKCTL_RST[adc_ctl_pkg::BIT_IE];
      ls_r <= adc_ctl_pkg::CLKCTL_RST[adc_ctl_pkg::BIT_LS];
      result_r <= {adc_ctl_pkg::UPPER_RST, adc_ctl_pkg::LOWER_RST[1:0]};
      lock_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 10'h000;
      hrdata_r <= 32'h0000_0000;
    end else begin
      on_r <= on_nxt;
      div_r <= div_nxt;
      chan_r <= chan_nxt;
      ie_r <= ie_nxt;
      ls_r <= ls_nxt;
      wr_pend_r <= accept && hwrite;
      wr_addr_r <= a_lo;
      // Set wins over the clear by the upper read; a fresh start clears it
      if (conv_done) eoc_r <= 1'b1;
      else if (rd_upper || start) eoc_r <= 1'b0;
      // Freeze covers the lower-read cycle so both halves stay one sample
      if (conv_done && !lock_r && !rd_lower) result_r <= sar_kept;
      if (rd_lower) lock_r <= 1'b1;
      else if (rd_upper || turn_off) lock_r <= 1'b0;
      if (rd_csr) hrdata_r <= {24'h000000, eoc_r, div_nxt, on_nxt, chan_nxt};
      else if (rd_upper) hrdata_r <= {24'h000000, result_r[9:2]};
      else if (rd_lower) hrdata_r <= {30'h0, result_r[1:0]};
      else if (rd_ctl) hrdata_r <= {30'h0, ls_nxt, ie_nxt};
      else if (accept) hrdata_r <= 32'h0000_0000;
    end
  end

  // ******************************
  // Sequencer
  // ******************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= adc_ctl_pkg::ST_OFF;
      div_cnt_r <= 8'h00;
      stab_r <= 16'h0000;
      step_r <= 4'h0;
      bit_r <= 4'h0;
      sar_r <= 10'h000;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || tick) div_cnt_r <= div_last(div_nxt);
      else div_cnt_r <= div_cnt_r - 8'h01;
      if (state_r != adc_ctl_pkg::ST_STAB) stab_r <= 16'(STAB_CYCLES - 1);
      else if (stab_r != 16'h0000) stab_r <= stab_r - 16'h0001;
      if (state_nxt != adc_ctl_pkg::ST_SAMPLE || state_r != adc_ctl_pkg::ST_SAMPLE) step_r <= 4'h0;
      else if (tick) step_r <= step_r + 4'h1;
      if (state_nxt == adc_ctl_pkg::ST_CONVERT && state_r != adc_ctl_pkg::ST_CONVERT) begin
        bit_r <= 4'(adc_ctl_pkg::RESULT_W - 1);
        sar_r <= 10'h200;
      end else if (state_r == adc_ctl_pkg::ST_CONVERT && tick && bit_r != 4'h0) begin
        bit_r <= bit_r - 4'h1;
        sar_r <= sar_kept | (trial >> 1);
      end
    end
  end

  // ******************************
  // Outputs
  // ******************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign converter_enable = (state_r != adc_ctl_pkg::ST_OFF);
  assign sample_hold = (state_r == adc_ctl_pkg::ST_SAMPLE);
  assign channel_sel = chan_r;
  assign dac_code = sar_r;
  assign done_irq = eoc_r && ie_r;

  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_DONE_SETS: assert property (conv_done |=> eoc_r)
    else $error("done flag not set after completion");
  AST_START_CLEARS: assert property (start && !halt_s_r |=> !eoc_r && state_r == adc_ctl_pkg::ST_SAMPLE)
    else $error("done flag high at conversion start");
  AST_UPPER_CLEARS: assert property (rd_upper && !conv_done |=> !eoc_r && !done_irq)
    else $error("upper read did not clear done");
  AST_RO_DONE: assert property (wr_csr && !eoc_r && !conv_done |=> !eoc_r)
    else $error("done flag written by software");
  AST_FROZEN: assert property (lock_r && !rd_upper |=> $stable(result_r))
    else $error("frozen result changed");
  AST_FREEZE: assert property (rd_lower |=> lock_r)
    else $error("lower read did not freeze");
  AST_UNFREEZE: assert property (rd_upper || turn_off |=> !lock_r)
    else $error("freeze not released");
  AST_OFF: assert property (turn_off |=> !converter_enable && !sample_hold)
    else $error("converter still running after off");
  AST_CHAN: assert property (chan_change && !halt_s_r |=> sample_hold && channel_sel == $past(hwdata[3:0]))
    else $error("channel change did not restart");
  AST_IRQ: assert property ($rose(eoc_r) && ie_r |-> done_irq)
    else $error("interrupt missing on completion");
  AST_LOWER_FMT: assert property (rd_lower |=> hrdata[31:2] == 30'h00000000)
    else $error("lower register upper bits not zero");
endmodule : sar_adc_control_readout
